// >>> hw/pllcfg_top.sv
`timescale 1ns/1ps
`default_nettype none
module pllcfg_top (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [9:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  output logic [7:0] RDATA_OUT,
  output logic PLL_ON_OUT,
  output logic OSC_ON_OUT,
  output logic PRESC_EXT_OUT,
  output logic SRC_INT_OUT,
  output logic DIV_BYPASS_OUT,
  output logic [2:0] DIV_RATIO_OUT,
  output logic DET_NEG_OUT,
  output logic [1:0] PUMP_MODE_OUT,
  output logic [1:0] ABL_WIDTH_OUT,
  output logic [2:0] REF_EN_OUT,
  output logic CAL_START_OUT
);
  logic rst_meta_ff;
  logic rst_n_ff;
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // staged copies written by software, active copies steer the clock path
  logic [7:0] stg_main_ff, stg_abl_ff, stg_cal_ff, stg_ref_ff;
  logic [7:0] stg_div_ff, stg_src_ff;
  logic [7:0] act_main_ff, act_abl_ff, act_cal_ff, act_ref_ff;
  logic [7:0] act_div_ff, act_src_ff;
  logic [7:0] nxt_stg_main, nxt_stg_abl, nxt_stg_cal, nxt_stg_ref;
  logic [7:0] nxt_stg_div, nxt_stg_src;
  logic [7:0] nxt_act_main, nxt_act_abl, nxt_act_cal, nxt_act_ref;
  logic [7:0] nxt_act_div, nxt_act_src;
  logic [7:0] rdata_ff, nxt_rdata;
  logic cal_start_ff, nxt_cal_start;
  logic xfer;

  assign xfer = WR_EN_IN && (ADDR_IN == pllcfg_pkg::OFS_XFER) &&
                WDATA_IN[pllcfg_pkg::POS_XFER];

  always_comb begin
    nxt_stg_main = stg_main_ff;
    nxt_stg_abl = stg_abl_ff;
    nxt_stg_cal = stg_cal_ff;
    nxt_stg_ref = stg_ref_ff;
    nxt_stg_div = stg_div_ff;
    nxt_stg_src = stg_src_ff;
    nxt_act_main = act_main_ff;
    nxt_act_abl = act_abl_ff;
    nxt_act_cal = act_cal_ff;
    nxt_act_ref = act_ref_ff;
    nxt_act_div = act_div_ff;
    nxt_act_src = act_src_ff;
    nxt_cal_start = 1'b0;
    nxt_rdata = rdata_ff;
    if (WR_EN_IN) begin
      case (ADDR_IN)
        pllcfg_pkg::OFS_PLL_MAIN: nxt_stg_main = WDATA_IN;
        pllcfg_pkg::OFS_ABL: nxt_stg_abl = WDATA_IN;
        pllcfg_pkg::OFS_CAL: nxt_stg_cal = WDATA_IN;
        pllcfg_pkg::OFS_REF: nxt_stg_ref = WDATA_IN;
        pllcfg_pkg::OFS_DIV: nxt_stg_div = WDATA_IN;
        pllcfg_pkg::OFS_SRC: nxt_stg_src = WDATA_IN;
        default: nxt_stg_main = stg_main_ff;
      endcase
    end
    if (xfer) begin
      nxt_act_main = stg_main_ff;
      nxt_act_abl = stg_abl_ff;
      nxt_act_cal = stg_cal_ff;
      nxt_act_ref = stg_ref_ff;
      nxt_act_div = stg_div_ff;
      nxt_act_src = stg_src_ff;
      // calibration start on rising calibrate bit
      nxt_cal_start = stg_cal_ff[pllcfg_pkg::POS_CAL] &&
                      !act_cal_ff[pllcfg_pkg::POS_CAL];
    end
    if (RD_EN_IN) begin
      case (ADDR_IN)
        pllcfg_pkg::OFS_PLL_MAIN: nxt_rdata = stg_main_ff;
        pllcfg_pkg::OFS_ABL: nxt_rdata = stg_abl_ff;
        pllcfg_pkg::OFS_CAL: nxt_rdata = stg_cal_ff;
        pllcfg_pkg::OFS_REF: nxt_rdata = stg_ref_ff;
        pllcfg_pkg::OFS_DIV: nxt_rdata = stg_div_ff;
        pllcfg_pkg::OFS_SRC: nxt_rdata = stg_src_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      stg_main_ff <= pllcfg_pkg::RST_PLL_MAIN;
      stg_abl_ff <= pllcfg_pkg::RST_ABL;
      stg_cal_ff <= pllcfg_pkg::RST_CAL;
      stg_ref_ff <= pllcfg_pkg::RST_REF;
      stg_div_ff <= pllcfg_pkg::RST_DIV;
      stg_src_ff <= pllcfg_pkg::RST_SRC;
      act_main_ff <= pllcfg_pkg::RST_PLL_MAIN;
      act_abl_ff <= pllcfg_pkg::RST_ABL;
      act_cal_ff <= pllcfg_pkg::RST_CAL;
      act_ref_ff <= pllcfg_pkg::RST_REF;
      act_div_ff <= pllcfg_pkg::RST_DIV;
      act_src_ff <= pllcfg_pkg::RST_SRC;
      cal_start_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      stg_main_ff <= nxt_stg_main;
      stg_abl_ff <= nxt_stg_abl;
      stg_cal_ff <= nxt_stg_cal;
      stg_ref_ff <= nxt_stg_ref;
      stg_div_ff <= nxt_stg_div;
      stg_src_ff <= nxt_stg_src;
      act_main_ff <= nxt_act_main;
      act_abl_ff <= nxt_act_abl;
      act_cal_ff <= nxt_act_cal;
      act_ref_ff <= nxt_act_ref;
      act_div_ff <= nxt_act_div;
      act_src_ff <= nxt_act_src;
      cal_start_ff <= nxt_cal_start;
      rdata_ff <= nxt_rdata;
    end
  end

  // decoded clock-path controls, registered from the active copies
  logic [1:0] pwr;
  logic [2:0] div_code;
  logic pll_on_ff, osc_on_ff, presc_ext_ff, src_int_ff, bypass_ff;
  logic det_neg_ff;
  logic [2:0] ratio_ff, ref_en_ff;
  logic [1:0] pump_mode_ff, abl_ff;
  logic nxt_pll_on, nxt_osc_on, nxt_presc_ext, nxt_src_int, nxt_bypass;
  logic nxt_det_neg;
  logic [2:0] nxt_ratio, nxt_ref_en;
  logic [1:0] nxt_pump_mode, nxt_abl;

  assign pwr = act_main_ff[pllcfg_pkg::POS_PWR_LO +: 2];
  assign div_code = act_div_ff[pllcfg_pkg::POS_DIV_LO +: 3];

  always_comb begin
    nxt_pll_on = (pwr == pllcfg_pkg::PWR_NORMAL);
    nxt_src_int = act_src_ff[pllcfg_pkg::POS_SRC_INT];
    nxt_bypass = act_src_ff[pllcfg_pkg::POS_BYPASS];
    nxt_osc_on = nxt_pll_on && nxt_src_int;
    nxt_presc_ext = nxt_pll_on && !nxt_src_int;
    if (div_code == pllcfg_pkg::DIV_CODE_TWO) begin
      nxt_ratio = pllcfg_pkg::DIV_RATIO_TWO;
    end else if (div_code > pllcfg_pkg::DIV_RATIO_MAX) begin
      nxt_ratio = pllcfg_pkg::DIV_RATIO_MAX;
    end else begin
      nxt_ratio = div_code;
    end
    nxt_det_neg = act_main_ff[pllcfg_pkg::POS_DET_POL];
    nxt_pump_mode = act_main_ff[pllcfg_pkg::POS_PUMP_LO +: 2];
    nxt_abl = act_abl_ff[pllcfg_pkg::POS_ABL_LO +: 2];
    nxt_ref_en = act_ref_ff[pllcfg_pkg::POS_REF_LO +: 3];
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pll_on_ff <= 1'b0;
      osc_on_ff <= 1'b0;
      presc_ext_ff <= 1'b0;
      src_int_ff <= 1'b0;
      bypass_ff <= 1'b0;
      ratio_ff <= pllcfg_pkg::DIV_RATIO_TWO;
      det_neg_ff <= 1'b0;
      pump_mode_ff <= 2'h0;
      abl_ff <= 2'h0;
      ref_en_ff <= 3'h0;
    end else begin
      pll_on_ff <= nxt_pll_on;
      osc_on_ff <= nxt_osc_on;
      presc_ext_ff <= nxt_presc_ext;
      src_int_ff <= nxt_src_int;
      bypass_ff <= nxt_bypass;
      ratio_ff <= nxt_ratio;
      det_neg_ff <= nxt_det_neg;
      pump_mode_ff <= nxt_pump_mode;
      abl_ff <= nxt_abl;
      ref_en_ff <= nxt_ref_en;
    end
  end

  assign RDATA_OUT = rdata_ff;
  assign PLL_ON_OUT = pll_on_ff;
  assign OSC_ON_OUT = osc_on_ff;
  assign PRESC_EXT_OUT = presc_ext_ff;
  assign SRC_INT_OUT = src_int_ff;
  assign DIV_BYPASS_OUT = bypass_ff;
  assign DIV_RATIO_OUT = ratio_ff;
  assign DET_NEG_OUT = det_neg_ff;
  assign PUMP_MODE_OUT = pump_mode_ff;
  assign ABL_WIDTH_OUT = abl_ff;
  assign REF_EN_OUT = ref_en_ff;
  assign CAL_START_OUT = cal_start_ff;

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!rst_n_ff);

  property p_pll_on;
    (pwr == pllcfg_pkg::PWR_NORMAL) |=> PLL_ON_OUT;
  endproperty
  a_pll_on: assert property (p_pll_on) else $error("pll not on");
  property p_pll_off;
    (pwr == pllcfg_pkg::PWR_ASYNC_DOWN) |=> !PLL_ON_OUT && !OSC_ON_OUT;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("pll not off");
  property p_src;
    $changed(act_src_ff) |=> SRC_INT_OUT == $past(act_src_ff[1]);
  endproperty
  a_src: assert property (p_src) else $error("source wrong");
  property p_bypass;
    xfer ##1 1'b1 |=> DIV_BYPASS_OUT == $past(act_src_ff[0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
  property p_ratio;
    1'b1 |=> DIV_RATIO_OUT >= 3'h1 && DIV_RATIO_OUT <= 3'h6 &&
      (($past(div_code) == 3'h0) == (DIV_RATIO_OUT == 3'h2 &&
       $past(div_code) != 3'h2));
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio wrong");
  property p_cal;
    (xfer && stg_cal_ff[0] && !act_cal_ff[0]) |=> CAL_START_OUT ##1
      !CAL_START_OUT;
  endproperty
  a_cal: assert property (p_cal) else $error("cal start missing");
  property p_cal_only;
    CAL_START_OUT |-> $past(xfer) && act_cal_ff[0];
  endproperty
  a_cal_only: assert property (p_cal_only) else $error("spurious cal");
  property p_pol;
    xfer ##1 1'b1 |=> DET_NEG_OUT == $past(act_main_ff[7]);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity wrong");
  property p_osc;
    PLL_ON_OUT && !SRC_INT_OUT |-> !OSC_ON_OUT && PRESC_EXT_OUT;
  endproperty
  a_osc: assert property (p_osc) else $error("osc not off");
  property p_abl_pump;
    xfer ##1 1'b1 |=> ABL_WIDTH_OUT == $past(act_abl_ff[1:0]) &&
      PUMP_MODE_OUT == $past(act_main_ff[3:2]);
  endproperty
  a_abl_pump: assert property (p_abl_pump)
    else $error("abl or pump wrong");
  property p_stage;
    !xfer |=> $stable(act_main_ff) && $stable(act_src_ff) &&
      $stable(act_div_ff);
  endproperty
  a_stage: assert property (p_stage) else $error("active changed");
  property p_xfer;
    xfer |=> act_main_ff == $past(stg_main_ff) &&
      act_src_ff == $past(stg_src_ff);
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer lost");
  c_cal: cover property (xfer && stg_cal_ff[0] ##1 CAL_START_OUT);
  c_int_mode: cover property (PLL_ON_OUT && OSC_ON_OUT && !DIV_BYPASS_OUT);
  c_bypass_mode: cover property (!PLL_ON_OUT && DIV_BYPASS_OUT);
  c_ext_pll: cover property (PRESC_EXT_OUT && DET_NEG_OUT);
endmodule // pllcfg_top
`default_nettype wire

// >>> hw/pllcfg_pkg.sv
package pllcfg_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam logic [9:0] OFS_PLL_MAIN = 10'h010;
  localparam logic [9:0] OFS_ABL = 10'h017;
  localparam logic [9:0] OFS_CAL = 10'h018;
  localparam logic [9:0] OFS_REF = 10'h01c;
  localparam logic [9:0] OFS_DIV = 10'h1e0;
  localparam logic [9:0] OFS_SRC = 10'h1e1;
  localparam logic [9:0] OFS_XFER = 10'h232;
  localparam int POS_PWR_LO = 0;
  localparam int POS_PUMP_LO = 2;
  localparam int POS_DET_POL = 7;
  localparam int POS_ABL_LO = 0;
  localparam int POS_CAL = 0;
  localparam int POS_REF_LO = 0;
  localparam int POS_DIV_LO = 0;
  localparam int POS_BYPASS = 0;
  localparam int POS_SRC_INT = 1;
  localparam int POS_XFER = 0;
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_ASYNC_DOWN = 2'h1;
  localparam logic [2:0] DIV_CODE_TWO = 3'h0;
  localparam logic [2:0] DIV_RATIO_TWO = 3'h2;
  localparam logic [2:0] DIV_RATIO_MAX = 3'h6;
  localparam logic [7:0] RST_PLL_MAIN = 8'h01;
  localparam logic [7:0] RST_ABL = 8'h00;
  localparam logic [7:0] RST_CAL = 8'h00;
  localparam logic [7:0] RST_REF = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h00;
  localparam logic [7:0] RST_SRC = 8'h00;
endpackage

// >>> dv/pllcfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module pllcfg_host (
  input wire logic clk_in,
  output logic [9:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_en_out,
  output logic rd_en_out
);
  initial begin
    addr_out = 10'h000;
    wdata_out = 8'h00;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
  end
  // one request per edge, launched just after the edge
  task automatic put(input logic [9:0] a, input logic [7:0] d,
    input logic w, input logic r);
    @(posedge clk_in);
    #2;
    addr_out = a;
    wdata_out = d;
    wr_en_out = w;
    rd_en_out = r;
  endtask
endmodule // pllcfg_host
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst_n, wr_en, rd_en, cal, act_cal;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, seed;
  wire [17:0] o;
  logic [17:0] cur;
  logic [7:0] stg [logic [9:0]];
  logic [7:0] rd_q [$];
  logic cal_q [$];
  logic [17:0] cfg_q [$];
  logic [2:0] xs = 3'h0;
  logic rs = 1'b0;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  pllcfg_host pllcfg_host_inst (.clk_in(clk), .addr_out(addr),
    .wdata_out(wdata), .wr_en_out(wr_en), .rd_en_out(rd_en));
  pllcfg_top pllcfg_top_inst (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_EN_IN(wr_en), .RD_EN_IN(rd_en),
    .RDATA_OUT(rdata), .PLL_ON_OUT(o[17]), .OSC_ON_OUT(o[16]),
    .PRESC_EXT_OUT(o[15]), .SRC_INT_OUT(o[14]), .DIV_BYPASS_OUT(o[13]),
    .DIV_RATIO_OUT(o[12:10]), .DET_NEG_OUT(o[9]), .PUMP_MODE_OUT(o[8:7]),
    .ABL_WIDTH_OUT(o[6:5]), .REF_EN_OUT(o[4:2]), .CAL_START_OUT(cal));
  assign o[1:0] = 2'h0;
  function automatic logic [17:0] efn();
    logic [7:0] m, s;
    logic [2:0] d;
    logic on;
    m = stg[pllcfg_pkg::OFS_PLL_MAIN];
    s = stg[pllcfg_pkg::OFS_SRC];
    d = stg[pllcfg_pkg::OFS_DIV][2:0];
    on = (m[1:0] == pllcfg_pkg::PWR_NORMAL);
    if (d == 3'h0) d = 3'h2;
    else if (d == 3'h7) d = 3'h6;
    return {on, on & s[1], on & ~s[1], s[1], s[0], d, m[7], m[3:2],
      stg[pllcfg_pkg::OFS_ABL][1:0], stg[pllcfg_pkg::OFS_REF][2:0], 2'h0};
  endfunction
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic tally(input string n, input logic [17:0] e, s);
    checks++;
    if (e !== s) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_rd(input logic [7:0] e);
    tally("read data", {10'h0, e}, {10'h0, rdata});
  endtask
  task automatic chk_cal(input logic e);
    tally("cal start", {17'h0, e}, {17'h0, cal});
  endtask
  task automatic chk_cfg(input logic [17:0] e);
    tally("config", e, o);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    pllcfg_host_inst.put(a, d, 1'b1, 1'b0);
    if (a == pllcfg_pkg::OFS_XFER) begin
      if (d[0]) begin
        cal_q.push_back(stg[pllcfg_pkg::OFS_CAL][0] & ~act_cal);
        act_cal = stg[pllcfg_pkg::OFS_CAL][0];
        cfg_q.push_back(efn());
      end
    end else if (stg.exists(a)) begin
      stg[a] = d;
    end
  endtask
  task automatic rd(input logic [9:0] a);
    pllcfg_host_inst.put(a, 8'h00, 1'b0, 1'b1);
    rd_q.push_back(stg.exists(a) ? stg[a] : 8'h00);
  endtask
  // transfer, then let the bus rest so transfers never abut
  task automatic xfer();
    wr(pllcfg_pkg::OFS_XFER, 8'h01);
    repeat (3) pllcfg_host_inst.put(~addr, ~wdata, 1'b0, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    xs <= {xs[1:0], wr_en && addr == pllcfg_pkg::OFS_XFER && wdata[0]};
    rs <= rd_en;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  always @(negedge clk) begin
    if (rs) chk_rd(rd_q.pop_front());
    if (xs[0]) chk_cal(cal_q.pop_front());
    else chk_cal(1'b0);
    if (xs[2]) cur = cfg_q.pop_front();
    if (xs == 3'h4 || xs == 3'h0) chk_cfg(cur);
  end
  initial begin
    rst_n = 1'b0;
    act_cal = 1'b0;
    seed = 8'h58;
    stg[pllcfg_pkg::OFS_PLL_MAIN] = pllcfg_pkg::RST_PLL_MAIN;
    stg[pllcfg_pkg::OFS_ABL] = pllcfg_pkg::RST_ABL;
    stg[pllcfg_pkg::OFS_CAL] = pllcfg_pkg::RST_CAL;
    stg[pllcfg_pkg::OFS_REF] = pllcfg_pkg::RST_REF;
    stg[pllcfg_pkg::OFS_DIV] = pllcfg_pkg::RST_DIV;
    stg[pllcfg_pkg::OFS_SRC] = pllcfg_pkg::RST_SRC;
    stg[pllcfg_pkg::OFS_XFER] = 8'h00;
    cur = efn();
    repeat (2) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (4) pllcfg_host_inst.put(~addr, ~wdata, 1'b0, 1'b0);
    foreach (stg[a]) rd(a);
    wr(10'h100, 8'hff);
    rd(10'h100);
    xfer();
    // reference on, divider kept for the internal source
    wr(pllcfg_pkg::OFS_PLL_MAIN, 8'h04);
    wr(pllcfg_pkg::OFS_REF, 8'h01);
    wr(pllcfg_pkg::OFS_DIV, 8'h03);
    wr(pllcfg_pkg::OFS_SRC, 8'h02);
    wr(pllcfg_pkg::OFS_CAL, 8'h01);
    wr(pllcfg_pkg::OFS_XFER, 8'h00);
    rd(pllcfg_pkg::OFS_SRC);
    xfer();
    xfer();
    wr(pllcfg_pkg::OFS_CAL, 8'h00);
    xfer();
    wr(pllcfg_pkg::OFS_CAL, 8'h01);
    xfer();
    wr(pllcfg_pkg::OFS_PLL_MAIN, 8'h01);
    wr(pllcfg_pkg::OFS_SRC, 8'h01);
    xfer();
    wr(pllcfg_pkg::OFS_PLL_MAIN, 8'h80);
    wr(pllcfg_pkg::OFS_SRC, 8'h00);
    xfer();
    for (int i = 0; i < 8; i++) begin
      wr(pllcfg_pkg::OFS_PLL_MAIN, {i[2], 3'h0, i[1:0], i[1:0]});
      wr(pllcfg_pkg::OFS_ABL, 8'(i));
      wr(pllcfg_pkg::OFS_DIV, 8'(i));
      wr(pllcfg_pkg::OFS_SRC, 8'(i));
      wr(pllcfg_pkg::OFS_REF, 8'(i));
      xfer();
    end
    for (int i = 0; i < 12; i++) begin
      foreach (stg[a]) begin
        seed = lfsr(seed);
        wr(a, seed);
      end
      rd(10'(seed) ^ 10'h1e0);
      xfer();
    end
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
